// >>> verilog/gpio_pkg.sv
// constants, carriers and register map of the general-purpose port set
//
// Contract
// - Port zero has four bits, each set to input or output by its own direction bit.
// - Each port zero bit has its own pull-up enable, independent of its neighbours.
// - After reset every port zero bit is an undriven input with its pull-up off.
// - Port one has five direction-controlled bits; after reset bits one to four are inputs with pull-ups off and bit zero drives low.
// - Port two is a four-bit input-only port with a per-bit pull-up, all off after reset.
// - The bit shared with the reset pin is open-drain and pulls the pin low when it holds zero and software starts a reset.
// - Holding the reset pin low puts the internal state back to its initial values, and raising it ends the reset; the code resets on aresetn only.
// - After reset release the device waits for a stable system clock before the reset service starts.
// - The key port has eight direction-controlled bits with per-bit pull-ups, all undriven inputs with pulls off after reset.
// - The two-bit port selects a pull-up or pull-down per bit, the two kinds are never mixed, and after reset both bits are inputs with no pull.
// - The LED port has eight direction-controlled bits with per-bit pull-ups, all undriven inputs with pulls off after reset.
// - The analog port selects a pull-up or pull-down per bit without mixing them, and after reset all its bits are inputs with no pull.
`default_nettype none

package gpio_pkg;

  // port indices
  localparam int         NUM_PORTS  = 7;
  localparam logic [2:0] P_ZERO     = 3'h0;
  localparam logic [2:0] P_ONE      = 3'h1;
  localparam logic [2:0] P_TWO      = 3'h2;
  localparam logic [2:0] P_KEY      = 3'h3;
  localparam logic [2:0] P_TWOBIT   = 3'h4;
  localparam logic [2:0] P_LED      = 3'h5;
  localparam logic [2:0] P_ANALOG   = 3'h6;

  // per-port capability masks, index 6 first
  localparam logic [NUM_PORTS-1:0][7:0] PIN_MASK =
    {8'hff, 8'hff, 8'h03, 8'hff, 8'h0f, 8'h1f, 8'h0f};
  localparam logic [NUM_PORTS-1:0][7:0] DIR_MASK =
    {8'hff, 8'hff, 8'h03, 8'hff, 8'h00, 8'h1f, 8'h0f};
  localparam logic [NUM_PORTS-1:0][7:0] PULLDOWN_MASK =
    {8'hff, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};

  // reset values
  localparam logic [NUM_PORTS-1:0][7:0] RESET_DIR =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  localparam logic [NUM_PORTS-1:0][7:0] RESET_DOUT = '0;
  localparam logic [NUM_PORTS-1:0][7:0] RESET_PULL = '0;
  localparam logic [NUM_PORTS-1:0][7:0] RESET_PSEL = '0;
  localparam logic                      RESET_SHARED_BIT = 1'b1;

  // register map: port block at port * 0x20, system word at 0xe0
  localparam int         ADDR_W        = 8;
  localparam logic [2:0] FLD_DOUT      = 3'h0;
  localparam logic [2:0] FLD_DIR       = 3'h1;
  localparam logic [2:0] FLD_PULL      = 3'h2;
  localparam logic [2:0] FLD_PSEL      = 3'h3;
  localparam logic [2:0] FLD_LEVEL     = 3'h4;
  localparam logic [7:0] SYS_CTRL_ADDR = 8'he0;
  localparam int         SYS_SHARED_BIT   = 0;
  localparam int         SYS_SOFT_RESET   = 1;
  localparam int         SYS_PIN_LEVEL    = 2;
  localparam int         SYS_CLOCK_STABLE = 3;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // timing
  localparam int unsigned CLK_PERIOD_NS       = 10;
  localparam int unsigned SOFT_RESET_NS       = 1000;
  localparam int unsigned SOFT_RESET_CYCLES   =
    (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLOCK_STABLE_NS     = 100000;
  localparam int unsigned CLOCK_STABLE_CYCLES =
    (CLOCK_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_lite_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_lite_rsp_s;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] o;
    logic [7:0] pu;
    logic [7:0] pd;
  } pad_out_s;

  typedef struct packed {
    logic       hit;
    logic       sys;
    logic [2:0] port;
    logic [2:0] field;
  } reg_sel_s;

  function automatic reg_sel_s reg_decode(input logic [ADDR_W-1:0] addr);
    reg_sel_s sel;
    sel       = '0;
    sel.port  = addr[7:5];
    sel.field = addr[4:2];
    if (addr == SYS_CTRL_ADDR) begin
      sel.sys = 1'b1;
      sel.hit = 1'b1;
    end else if (addr[1:0] == 2'h0 && addr[7:5] < 3'(NUM_PORTS) && addr[4:2] <= FLD_LEVEL) begin
      sel.hit = 1'b1;
    end
    return sel;
  endfunction

endpackage

`default_nettype wire

// >>> verilog/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // pins and sampled level
  input  wire logic [WIDTH-1:0] pin_raw,
  output var  logic [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_state_s;

  sync_state_s s;
  sync_state_s next_s;

  // s1 feeds s2 only; the filter looks at s2 and s3
  always_comb begin
    next_s    = s;
    next_s.s1 = pin_raw;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.lvl[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.lvl;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_level_agreed: assert property (
    ##1 ((s.lvl ^ $past(s.lvl)) & ($past(s.s2) ^ $past(s.s3))) == '0
        && (($past(s.s2) ~^ $past(s.s3)) & (s.lvl ^ $past(s.s3))) == '0)
    else $error("sampled level changed without stage agreement");

endmodule

`default_nettype wire

// >>> verilog/reset_control.sv
// clock-stable wait after reset release and software reset pin drive
`default_nettype none

module reset_control
  import gpio_pkg::*;
#(
  parameter int unsigned STABLE_CYCLES = CLOCK_STABLE_CYCLES
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // software request
  input  wire logic soft_req,
  input  wire logic shared_bit,
  // status
  output var  logic pin_drive,
  output var  logic clock_stable
);

  localparam logic [15:0] STABLE_LAST = 16'(STABLE_CYCLES - 1);
  localparam logic [7:0]  DRIVE_LAST  = 8'(SOFT_RESET_CYCLES - 1);

  typedef struct packed {
    logic [15:0] wait_cnt;
    logic        stable;
    logic [7:0]  drive_cnt;
    logic        drive;
  } rst_state_s;

  rst_state_s s;
  rst_state_s next_s;

  always_comb begin
    next_s = s;
    if (!s.stable) begin
      next_s.wait_cnt = s.wait_cnt + 16'h0001;
      if (s.wait_cnt == STABLE_LAST) begin
        next_s.stable = 1'b1;
      end
    end
    // open-drain pull only when the shared bit holds zero
    if (soft_req && !shared_bit && !s.drive) begin
      next_s.drive     = 1'b1;
      next_s.drive_cnt = 8'h00;
    end else if (s.drive) begin
      if (s.drive_cnt == DRIVE_LAST) begin
        next_s.drive = 1'b0;
      end else begin
        next_s.drive_cnt = s.drive_cnt + 8'h01;
      end
    end
  end

  // the pin drive ends early if the pin loop resets this block itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pin_drive    = s.drive;
  assign clock_stable = s.stable;

  // helper: cycles since reset release, saturating
  logic [16:0] since_release;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_release <= '0;
    end else if (!since_release[16]) begin
      since_release <= since_release + 17'h00001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stable_not_early: assert property (
    s.stable && !since_release[16] |-> int'(since_release) >= int'(STABLE_CYCLES))
    else $error("clock stable flagged before the wait elapsed");

  a_stable_on_time: assert property (
    !s.stable && int'(since_release) == int'(STABLE_CYCLES) - 1 |=> s.stable)
    else $error("clock stable not flagged after the wait");

  a_drive_cause: assert property (
    $rose(s.drive) |-> $past(soft_req) && !$past(shared_bit))
    else $error("reset pin driven without a software reset on a zero bit");

  a_drive_length: assert property (
    $rose(s.drive) |-> s.drive[*8])
    else $error("reset pin drive too short");

  a_drive_end: assert property (
    $fell(s.drive) |-> $past(s.drive_cnt) == DRIVE_LAST)
    else $error("reset pin drive ended at the wrong count");

endmodule

`default_nettype wire

// >>> verilog/gpio_port_set.sv
// general-purpose port set with its axi4-lite register slave
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`default_nettype none

module gpio_port_set
  import gpio_pkg::*;
#(
  parameter int unsigned STABLE_CYCLES = CLOCK_STABLE_CYCLES
) (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // register bus
  input  wire axi_lite_req_s                 axi_req,
  output var  axi_lite_rsp_s                 axi_rsp,
  // port pins
  input  wire logic [NUM_PORTS-1:0][7:0]     pad_in,
  output var  pad_out_s [NUM_PORTS-1:0]      pad_out,
  // reset pin shared with a port bit
  input  wire logic                          reset_pin_n_in,
  output var  logic                          reset_pin_n_o,
  output var  logic                          reset_pin_n_oe,
  // reset service may start
  output var  logic                          clock_stable
);

  typedef struct packed {
    logic [NUM_PORTS-1:0][7:0] dout;
    logic [NUM_PORTS-1:0][7:0] dir;
    logic [NUM_PORTS-1:0][7:0] pull;
    logic [NUM_PORTS-1:0][7:0] psel;
    pad_out_s [NUM_PORTS-1:0]  pad;
    logic                      reset_shared_port_bit;
    logic                      soft_pulse;
    logic                      rst_o;
    logic                      rst_oe;
    logic                      stable;
    logic                      aw_got;
    logic [ADDR_W-1:0]         awaddr;
    logic                      w_got;
    logic [31:0]               wdata;
    logic                      wstrb0;
    axi_lite_rsp_s             rsp;
  } top_state_s;

  top_state_s s;
  top_state_s next_s;

  logic [NUM_PORTS*8:0]      sync_level;
  logic [NUM_PORTS-1:0][7:0] pin_level;
  logic                      reset_pin_level;
  logic                      pin_drive;
  logic                      stable_raw;

  pin_sync #(
    .WIDTH (NUM_PORTS * 8 + 1)
  ) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_raw ({reset_pin_n_in, pad_in}),
    .level   (sync_level)
  );

  assign pin_level       = sync_level[NUM_PORTS*8-1:0];
  assign reset_pin_level = sync_level[NUM_PORTS*8];

  reset_control #(
    .STABLE_CYCLES (STABLE_CYCLES)
  ) u_reset_control (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .soft_req     (s.soft_pulse),
    .shared_bit   (s.reset_shared_port_bit),
    .pin_drive    (pin_drive),
    .clock_stable (stable_raw)
  );

  reg_sel_s   sel_w;
  reg_sel_s   sel_r;
  logic [7:0] in_bits;
  logic [7:0] up;
  logic [7:0] dn;
  logic [7:0] rd_byte;

  always_comb begin
    next_s            = s;
    sel_w             = reg_decode(s.awaddr);
    sel_r             = reg_decode(axi_req.araddr);
    in_bits           = 8'h00;
    up                = 8'h00;
    dn                = 8'h00;
    rd_byte           = 8'h00;
    next_s.soft_pulse = 1'b0;

    // write address and data are taken in either order
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_got  = 1'b1;
      next_s.wdata  = axi_req.wdata;
      next_s.wstrb0 = axi_req.wstrb[0];
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      next_s.aw_got    = 1'b0;
      next_s.w_got     = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = sel_w.hit ? RESP_OKAY : RESP_SLVERR;
      // all fields live in the low byte, so lane zero alone matters
      if (sel_w.hit && s.wstrb0) begin
        if (sel_w.sys) begin
          next_s.reset_shared_port_bit = s.wdata[SYS_SHARED_BIT];
          next_s.soft_pulse            = s.wdata[SYS_SOFT_RESET];
        end else begin
          case (sel_w.field)
            FLD_DOUT: next_s.dout[sel_w.port] = s.wdata[7:0] & DIR_MASK[sel_w.port];
            FLD_DIR:  next_s.dir[sel_w.port]  = s.wdata[7:0] & DIR_MASK[sel_w.port];
            FLD_PULL: next_s.pull[sel_w.port] = s.wdata[7:0] & PIN_MASK[sel_w.port];
            FLD_PSEL: next_s.psel[sel_w.port] =
                        s.wdata[7:0] & PULLDOWN_MASK[sel_w.port];
            default:  next_s.rsp.bresp = RESP_OKAY;
          endcase
        end
      end
    end

    // read channel: one read under way at a time
    if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp  = sel_r.hit ? RESP_OKAY : RESP_SLVERR;
      if (sel_r.hit && sel_r.sys) begin
        rd_byte[SYS_SHARED_BIT]   = s.reset_shared_port_bit;
        rd_byte[SYS_PIN_LEVEL]    = reset_pin_level;
        rd_byte[SYS_CLOCK_STABLE] = s.stable;
      end else if (sel_r.hit) begin
        case (sel_r.field)
          FLD_DOUT:  rd_byte = s.dout[sel_r.port];
          FLD_DIR:   rd_byte = s.dir[sel_r.port];
          FLD_PULL:  rd_byte = s.pull[sel_r.port];
          FLD_PSEL:  rd_byte = s.psel[sel_r.port];
          FLD_LEVEL: rd_byte = ((s.dir[sel_r.port] & s.dout[sel_r.port])
                               | (~s.dir[sel_r.port] & pin_level[sel_r.port]))
                               & PIN_MASK[sel_r.port];
          default:   rd_byte = 8'h00;
        endcase
      end
      next_s.rsp.rdata = {24'h000000, rd_byte};
    end

    next_s.rsp.awready = !next_s.aw_got && !next_s.rsp.bvalid;
    next_s.rsp.wready  = !next_s.w_got && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;

    // pad drivers; pulls act on input bits only
    for (int p = 0; p < NUM_PORTS; p++) begin
      in_bits = ~s.dir[p] & PIN_MASK[p];
      up = s.pull[p] & in_bits & (~s.psel[p] | ~PULLDOWN_MASK[p]);
      dn = s.pull[p] & in_bits & s.psel[p] & PULLDOWN_MASK[p];
      // a mixed setting is refused outright rather than fighting itself
      if (|up && |dn) begin
        up = 8'h00;
        dn = 8'h00;
      end
      next_s.pad[p].oe = s.dir[p] & DIR_MASK[p];
      next_s.pad[p].o  = s.dout[p] & s.dir[p] & DIR_MASK[p];
      next_s.pad[p].pu = up;
      next_s.pad[p].pd = dn;
    end

    // open-drain: the output level is always low, only the enable moves
    next_s.rst_o  = 1'b0;
    next_s.rst_oe = pin_drive;
    next_s.stable = stable_raw;
  end

  function automatic pad_out_s pad_reset(input int p);
    pad_out_s v;
    v    = '0;
    v.oe = RESET_DIR[p];
    v.o  = RESET_DOUT[p];
    return v;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s                       <= '0;
      s.dout                  <= RESET_DOUT;
      s.dir                   <= RESET_DIR;
      s.pull                  <= RESET_PULL;
      s.psel                  <= RESET_PSEL;
      s.reset_shared_port_bit <= RESET_SHARED_BIT;
      for (int p = 0; p < NUM_PORTS; p++) begin
        s.pad[p] <= pad_reset(p);
      end
    end else begin
      s <= next_s;
    end
  end

  assign axi_rsp        = s.rsp;
  assign pad_out        = s.pad;
  assign reset_pin_n_o  = s.rst_o;
  assign reset_pin_n_oe = s.rst_oe;
  assign clock_stable   = s.stable;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_port0_reset_idle: assert property (
    $rose(aresetn) |-> s.pad[P_ZERO].oe == 8'h00 && s.pad[P_ZERO].pu == 8'h00)
    else $error("port zero not an idle input after reset");

  a_port1_reset_low: assert property (
    $rose(aresetn) |-> s.pad[P_ONE].oe == 8'h01 && s.pad[P_ONE].o == 8'h00
                       && s.pad[P_ONE].pu == 8'h00)
    else $error("port one reset state wrong");

  a_port2_no_drive: assert property (
    s.pad[P_TWO].oe == 8'h00
    and ($rose(aresetn) |-> s.pad[P_TWO].pu == 8'h00))
    else $error("input-only port driven or pulled after reset");

  a_wide_reset_idle: assert property (
    $rose(aresetn) |-> s.pad[P_KEY].oe == 8'h00 && s.pad[P_LED].oe == 8'h00
                       && s.pad[P_KEY].pu == 8'h00 && s.pad[P_LED].pu == 8'h00)
    else $error("key or led port not idle after reset");

  a_twobit_no_mix: assert property (
    !(|s.pad[P_TWOBIT].pu && |s.pad[P_TWOBIT].pd)
    and ($rose(aresetn) |-> s.pad[P_TWOBIT] == '0))
    else $error("two-bit port pulls mixed or active after reset");

  a_analog_no_mix: assert property (
    !(|s.pad[P_ANALOG].pu && |s.pad[P_ANALOG].pd)
    and ($rose(aresetn) |-> s.pad[P_ANALOG] == '0))
    else $error("analog port pulls mixed or active after reset");

  a_output_follows: assert property (
    ##1 s.pad[P_ZERO].oe == $past(s.dir[P_ZERO])
        && s.pad[P_LED].o == $past(s.dout[P_LED] & s.dir[P_LED]))
    else $error("pad drive does not follow direction and data");

  a_pullup_per_bit: assert property (
    ##1 s.pad[P_ZERO].pu == $past(s.pull[P_ZERO] & ~s.dir[P_ZERO] & 8'h0f))
    else $error("port zero pull-up not per bit");

  a_reset_pin_od: assert property (
    s.rst_o == 1'b0
    and (s.rst_oe |-> $past(pin_drive)))
    else $error("reset pin driven other than open-drain low");

  a_write_answer: assert property (
    s.aw_got && s.w_got && !s.rsp.bvalid |=> s.rsp.bvalid && !s.rsp.awready)
    else $error("write not answered one cycle after both halves");

  a_read_answer: assert property (
    axi_req.arvalid && s.rsp.arready |=> s.rsp.rvalid && !s.rsp.arready)
    else $error("read not answered one cycle after the address");

  a_refused_write: assert property (
    s.aw_got && s.w_got && !s.rsp.bvalid && !sel_w.hit
    |=> s.rsp.bresp == RESP_SLVERR && $stable(s.dir) && $stable(s.dout))
    else $error("unmapped write not refused");

  a_port2_input_only: assert property (
    s.dir[P_TWO] == 8'h00 && s.dout[P_TWO] == 8'h00)
    else $error("input-only port holds a drive setting");

  a_soft_pulse_single: assert property (
    s.soft_pulse |=> !s.soft_pulse)
    else $error("software reset request longer than one cycle");

  a_stable_follows: assert property (
    ##1 s.stable == $past(stable_raw))
    else $error("clock stable output out of step");

  a_stable_holds: assert property (
    s.stable |=> s.stable)
    else $error("clock stable dropped without a reset");

  a_pull_off_outputs: assert property (
    (s.pad[P_KEY].pu & s.pad[P_KEY].oe) == 8'h00
    && (s.pad[P_LED].pu & s.pad[P_LED].oe) == 8'h00)
    else $error("pull-up active on a driven bit");

  a_port0_width: assert property (
    ((s.pad[P_ZERO].oe | s.pad[P_ZERO].pu | s.pad[P_ZERO].pd) & ~PIN_MASK[P_ZERO]) == 8'h00)
    else $error("port zero acts on a missing bit");

  a_port1_width: assert property (
    ((s.pad[P_ONE].oe | s.pad[P_ONE].pu | s.pad[P_ONE].pd) & ~PIN_MASK[P_ONE]) == 8'h00)
    else $error("port one acts on a missing bit");

  a_inputs_undriven: assert property (
    ##1 (s.pad[P_KEY].oe & ~$past(s.dir[P_KEY])) == 8'h00)
    else $error("key port drives an input bit");

endmodule

`default_nettype wire

// >>> verification/board_model.sv
// board circuitry on the port pins and on the reset line
`default_nettype none

module board_model
  import gpio_pkg::*;
(
  // clock
  input  wire logic                      aclk,
  // device pin drive
  input  wire pad_out_s [NUM_PORTS-1:0]  pad_out,
  input  wire logic                      rst_oe,
  // external drivers set by the bench
  input  wire logic [NUM_PORTS-1:0][7:0] ext_en,
  input  wire logic [NUM_PORTS-1:0][7:0] ext_val,
  // resolved pin levels
  output logic [NUM_PORTS-1:0][7:0]      pad_in,
  output logic                           rst_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [NUM_PORTS-1:0][7:0] flt = '0;

  // undriven, unpulled pins wander so a stale value never reads as valid
  always @(posedge aclk) begin
    flt <= ~flt;
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pad_out[p].oe[b]) begin
          pad_in[p][b] = pad_out[p].o[b];
        end else if (ext_en[p][b]) begin
          pad_in[p][b] = ext_val[p][b];
        end else if (pad_out[p].pu[b]) begin
          pad_in[p][b] = 1'b1;
        end else if (pad_out[p].pd[b]) begin
          pad_in[p][b] = 1'b0;
        end else begin
          pad_in[p][b] = flt[p][b];
        end
      end
    end
  end

  // reset line idles high through its pull-up, low only while pulled down
  assign rst_pin = !rst_oe;
endmodule

`default_nettype wire

// >>> verification/general_purpose_port_set_bench.sv
// self-checking bench for the general-purpose port set
`default_nettype none

module general_purpose_port_set_bench
  import gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SC = 20;
  logic                      aclk, aresetn, rst_pin, rst_o, rst_oe, stable;
  axi_lite_req_s             req;
  axi_lite_rsp_s             rsp;
  logic [NUM_PORTS-1:0][7:0] pad_in, ext_en, ext_val;
  pad_out_s [NUM_PORTS-1:0]  pad_out;
  int                        err_total, checks, oe_cnt;
  logic [7:0]                msk [NUM_PORTS] = '{8'h0f, 8'h1f, 8'h0f, 8'hff, 8'h03, 8'hff, 8'hff};

  gpio_port_set #(.STABLE_CYCLES(SC)) i_gpio_port_set (.aclk(aclk), .aresetn(aresetn),
    .axi_req(req), .axi_rsp(rsp), .pad_in(pad_in), .pad_out(pad_out),
    .reset_pin_n_in(rst_pin), .reset_pin_n_o(rst_o), .reset_pin_n_oe(rst_oe),
    .clock_stable(stable));
  board_model i_board_model (.aclk(aclk), .pad_out(pad_out), .rst_oe(rst_oe),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in), .rst_pin(rst_pin));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (rst_oe === 1'b1) oe_cnt <= oe_cnt + 1;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    err_total++;
    $display("[FAIL] %s expected answer seen none", nm);
    finish_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // bready and rready stay high, so only valids move here
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    do begin
      @(posedge aclk);
      n++;
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (n > 50) hang("write response");
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    do begin
      @(posedge aclk);
      n++;
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (n > 50) hang("read response");
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("write resp", RESP_OKAY, r);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, e, d);
    chk("read resp", RESP_OKAY, r);
  endtask

  task automatic t_reset();
    int n;
    aresetn <= 1'b0;
    cyc(12);
    for (int p = 0; p < NUM_PORTS; p++) begin
      chk("pad reset", {(p == 1) ? 8'h01 : 8'h00, 24'h0}, pad_out[p]);
    end
    chk("pin drive reset", 0, rst_oe);
    aresetn <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (stable !== 1'b1 && n < 60);
    if (stable !== 1'b1) hang("clock stable");
    @(posedge aclk);
    chk("stable wait", SC + 1, n);
    for (int p = 0; p < NUM_PORTS; p++) begin
      rchk("dir reset", 8'(p * 32 + 4), (p == 1) ? 32'h1 : 32'h0);
      rchk("pull reset", 8'(p * 32 + 8), 32'h0);
      rchk("psel reset", 8'(p * 32 + 12), 32'h0);
    end
    $display("test reset done");
  endtask

  task automatic t_dir();
    logic [7:0] e;
    for (int p = 0; p < NUM_PORTS; p++) begin
      e = (p == 2) ? 8'h00 : msk[p];
      wreg(8'(p * 32), 32'ha5);
      wreg(8'(p * 32 + 4), 32'hff);
      cyc(8);
      chk("drive en", e, pad_out[p].oe);
      chk("drive val", 8'ha5 & e, pad_out[p].o);
      if (p != 2) rchk("out level", 8'(p * 32 + 16), 8'ha5 & e);
      wreg(8'(p * 32 + 4), 32'h0);
      ext_en[p]  <= 8'hff;
      ext_val[p] <= 8'h3c;
      cyc(8);
      chk("released", 0, pad_out[p].oe);
      rchk("in level", 8'(p * 32 + 16), 8'h3c & msk[p]);
      ext_en[p] <= 8'h00;
    end
    $display("test dir done");
  endtask

  // sparse pattern shows each pull bit acts alone
  task automatic t_pull();
    logic [7:0]  e;
    logic [31:0] d;
    logic [1:0]  r;
    for (int p = 0; p < NUM_PORTS; p++) begin
      e = 8'ha5 & msk[p];
      wreg(8'(p * 32 + 8), {24'h0, e});
      cyc(8);
      chk("pull up", {e, 8'h00}, {pad_out[p].pu, pad_out[p].pd});
      rd(8'(p * 32 + 16), d, r);
      chk("pulled high", e, d[7:0] & e);
      if (p == 4 || p == 6) begin
        wreg(8'(p * 32 + 12), {24'h0, msk[p]});
        cyc(8);
        chk("pull down", {8'h00, e}, {pad_out[p].pu, pad_out[p].pd});
        rd(8'(p * 32 + 16), d, r);
        chk("pulled low", 0, d[7:0] & e);
        wreg(8'(p * 32 + 8), {24'h0, msk[p]});
        wreg(8'(p * 32 + 12), 32'h1);
        cyc(8);
        chk("mixed pulls", 0, {pad_out[p].pu, pad_out[p].pd});
        wreg(8'(p * 32 + 12), 32'h0);
      end
      wreg(8'(p * 32 + 8), 32'h0);
    end
    $display("test pull done");
  endtask

  task automatic t_soft();
    int n;
    wreg(SYS_CTRL_ADDR, 32'h3);
    cyc(20);
    chk("no pin drive", 0, rst_oe);
    wreg(SYS_CTRL_ADDR, 32'h2);
    cyc(10);
    chk("pin drive", 1, rst_oe);
    chk("open drain", 0, rst_o);
    rchk("pin low", SYS_CTRL_ADDR, 32'h8);
    n = 0;
    while (rst_oe !== 1'b0) begin
      @(posedge aclk);
      n++;
      if (n > 300) hang("pin drive end");
    end
    cyc(8);
    chk("drive length", SOFT_RESET_CYCLES, oe_cnt);
    rchk("pin high", SYS_CTRL_ADDR, 32'hc);
    wreg(SYS_CTRL_ADDR, 32'h1);
    $display("test soft reset done");
  endtask

  task automatic t_bad();
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'hfc, d, r);
    chk("bad read resp", RESP_SLVERR, r);
    chk("bad read data", 0, d);
    wr(8'h14, 32'h1, r);
    chk("bad write resp", RESP_SLVERR, r);
    wr(8'h01, 32'h1, r);
    chk("unaligned resp", RESP_SLVERR, r);
    $display("test refused done");
  endtask

  initial begin
    aresetn     = 1'b0;
    req         = '0;
    req.bready  = 1'b1;
    req.rready  = 1'b1;
    ext_en      = '0;
    ext_val     = '0;
    err_total   = 0;
    checks      = 0;
    @(posedge aclk);
    t_reset();
    t_dir();
    t_pull();
    t_soft();
    t_bad();
    wreg(8'h04, 32'hf);
    t_reset();
    finish_test();
  end
endmodule

`default_nettype wire
